/* File: shared/bsr_pkg.sv */
// Constants and types shared by the burst SRAM device and controller ends
package bsr_pkg;
	localparam int BSR_ADDR_W = 8;
	localparam int BSR_DATA_W = 18;
	localparam int BSR_LANE_W = 9;
	localparam int BSR_LANES = BSR_DATA_W / BSR_LANE_W;
	localparam int BSR_CAL_PERIOD = 1024;
	localparam int BSR_CAL_W = 10;
	localparam int BSR_CLK_NS = 40;
	typedef enum logic [1:0] {
		BSR_IDLE = 2'b00,
		BSR_BEAT0 = 2'b01,
		BSR_BEAT1 = 2'b10
	} bsr_rd_state_t;
endpackage

/* File: shared/bsr_if.sv */
// Pin-level link between burst SRAM device and its controller
interface bsr_if import bsr_pkg::*; #(
	parameter int DATA_W = BSR_DATA_W,
	parameter int ADDR_W = BSR_ADDR_W
) ();
	localparam int LANES = DATA_W / BSR_LANE_W;
	logic in_clk_phase;
	logic [ADDR_W-1:0] addr;
	logic read_port_select_n;
	logic write_port_select_n;
	logic [LANES-1:0] byte_lane_write_select_n;
	logic [DATA_W-1:0] wr_data;
	logic out_clk_hold_high;
	logic [DATA_W-1:0] rd_data;
	logic rd_data_oe;
	logic rd_data_valid;
	modport dev (
		input in_clk_phase, addr, read_port_select_n, write_port_select_n,
		input byte_lane_write_select_n, wr_data, out_clk_hold_high,
		output rd_data, rd_data_oe, rd_data_valid
	);
	modport ctl (
		output in_clk_phase, addr, read_port_select_n, write_port_select_n,
		output byte_lane_write_select_n, wr_data, out_clk_hold_high,
		input rd_data, rd_data_oe, rd_data_valid
	);
endinterface

/* File: rtl/bsr_device.sv */
// Burst-of-two SRAM device end with separate read and write ports
// Functional notes
// (R1) Port selects sampled on true phase only
// (R2) Each select deselects only its own port
// (R3) Pending transfers finish before deselect
// (R4) Impedance recalibrated every 1024 cycles
// (R5) Write: word0 true phase, address+word1 next
// (R6) Read: address on true phase, burst after wait
// (R7) Power up deselected, outputs high impedance
// (R8) Data registered on clock rises
// (R9) Controller may park clocks at equal levels
// (R10) 18-bit: two lane selects mask bytes
// (R11) 36-bit: four lane selects mask bytes
// (R12) All lanes high writes nothing
// (R13) Lane selects apply per sampled word
// (R14) Single clock mode strapped at power-up
// (R15) Outputs float after burst ends
// (R16) Forward previous write data to read
// (R17) No operation ignores data, outputs float
// (R18) Stopped clocks hold all state
module bsr_device import bsr_pkg::*; #(
	parameter int DATA_W = BSR_DATA_W,
	parameter int ADDR_W = BSR_ADDR_W
) (
	input wire logic clk,
	input wire logic srst,
	bsr_if.dev link,
	output logic cal_pulse,
	output logic single_clock_mode
);
	localparam int LANES = DATA_W / BSR_LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	initial begin
		if (DATA_W != 18 && DATA_W != 36)
			$error("DATA_W must be 18 or 36");
	end
	logic [DATA_W-1:0] mem0 [DEPTH];
	logic [DATA_W-1:0] mem1 [DEPTH];
	wire phase_true = link.in_clk_phase; // R1 R18
	logic wr_pend;
	logic [DATA_W-1:0] wr_word0;
	logic [LANES-1:0] wr_lane0_n;
	logic [BSR_CAL_W-1:0] cal_cnt;
	logic strap_taken;
	bsr_rd_state_t rd_state;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_word1;
	logic [DATA_W-1:0] rd_data;
	logic rd_oe;
	logic [DATA_W-1:0] wr_word1_full;
	logic [DATA_W-1:0] wr_word0_full;
	logic [DATA_W-1:0] mask0;
	logic [DATA_W-1:0] mask1;
	logic [ADDR_W-1:0] last_wr_addr;
	logic last_wr_valid;
	logic [DATA_W-1:0] last_w0;
	logic [DATA_W-1:0] last_w1;
	// Expand active-low lane selects to bit masks
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			mask0[i*BSR_LANE_W +: BSR_LANE_W] = {BSR_LANE_W{~wr_lane0_n[i]}}; // R10 R11 R13
			mask1[i*BSR_LANE_W +: BSR_LANE_W] = {BSR_LANE_W{~link.byte_lane_write_select_n[i]}}; // R10 R11 R13
		end
	end
	wire wr_commit = wr_pend && !phase_true; // R5 R3
	wire rd_start = phase_true && !link.read_port_select_n && rd_state == BSR_IDLE; // R1 R2 R6
	wire wr_start = phase_true && !link.write_port_select_n; // R1 R2 R5
	wire [ADDR_W-1:0] wa = link.addr;
	assign wr_word0_full = (mem0[wa] & ~mask0) | (wr_word0 & mask0); // R12
	assign wr_word1_full = (mem1[wa] & ~mask1) | (link.wr_data & mask1); // R12
	wire fwd = last_wr_valid && last_wr_addr == rd_addr; // R16
	wire [DATA_W-1:0] rd0 = fwd ? last_w0 : mem0[rd_addr];
	wire [DATA_W-1:0] rd1 = fwd ? last_w1 : mem1[rd_addr];
	always_ff @(posedge clk) begin
		if (wr_commit) begin
			mem0[wa] <= wr_word0_full; // R8
			mem1[wa] <= wr_word1_full;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_pend <= 1'b0; // R7
			wr_word0 <= '0;
			wr_lane0_n <= '1;
			last_wr_valid <= 1'b0;
			last_wr_addr <= '0;
			last_w0 <= '0;
			last_w1 <= '0;
		end else begin
			if (wr_start) begin
				wr_pend <= 1'b1;
				wr_word0 <= link.wr_data; // R5 R8
				wr_lane0_n <= link.byte_lane_write_select_n; // R13
			end else if (wr_commit) begin
				wr_pend <= 1'b0;
			end
			if (wr_commit) begin
				last_wr_valid <= 1'b1;
				last_wr_addr <= wa;
				last_w0 <= wr_word0_full;
				last_w1 <= wr_word1_full;
			end else if (phase_true) begin
				last_wr_valid <= 1'b0;
			end
		end
	end
	// Read burst: wait one cycle, then two beats, then float
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_state <= BSR_IDLE; // R7
			rd_addr <= '0;
			rd_data <= '0;
			rd_word1 <= '0;
			rd_oe <= 1'b0;
		end else begin
			case (rd_state)
				BSR_IDLE: begin
					rd_oe <= 1'b0; // R15 R17
					if (rd_start) begin
						rd_addr <= link.addr; // R6
						rd_state <= BSR_BEAT0;
					end
				end
				BSR_BEAT0: begin
					if (phase_true) begin
						rd_data <= rd0; // R6 R16
						rd_word1 <= rd1;
						rd_oe <= 1'b1;
						rd_state <= BSR_BEAT1;
					end
				end
				BSR_BEAT1: begin
					rd_data <= rd_word1; // R3 R8
					rd_state <= BSR_IDLE; // R15
				end
				default: rd_state <= BSR_IDLE;
			endcase
		end
	end
	// Periodic impedance recalibration
	always_ff @(posedge clk) begin
		if (srst) begin
			cal_cnt <= '0;
			cal_pulse <= 1'b0;
		end else begin
			cal_cnt <= (cal_cnt == BSR_CAL_W'(BSR_CAL_PERIOD - 1)) ? '0 : cal_cnt + 1'b1; // R4
			cal_pulse <= cal_cnt == BSR_CAL_W'(BSR_CAL_PERIOD - 1); // R4
		end
	end
	// Single clock mode strap caught after reset release
	always_ff @(posedge clk) begin
		if (srst) begin
			strap_taken <= 1'b0;
			single_clock_mode <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			single_clock_mode <= link.out_clk_hold_high; // R14
		end
	end
	assign link.rd_data = rd_data;
	assign link.rd_data_oe = rd_oe; // R15 R7
	assign link.rd_data_valid = rd_oe;
endmodule

/* File: rtl/bsr_controller.sv */
// Controller end driving burst SRAM writes and reads
module bsr_controller import bsr_pkg::*; #(
	parameter int DATA_W = BSR_DATA_W,
	parameter int ADDR_W = BSR_ADDR_W
) (
	input wire logic clk,
	input wire logic srst,
	bsr_if.ctl link,
	input wire logic single_clock,
	input wire logic wr_req,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [2*DATA_W-1:0] wr_burst,
	input wire logic [2*(DATA_W/BSR_LANE_W)-1:0] wr_lanes_n,
	input wire logic rd_req,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic req_ready,
	output logic [2*DATA_W-1:0] rd_burst,
	output logic rd_done
);
	localparam int LANES = DATA_W / BSR_LANE_W;
	logic phase_true;
	logic wr_second;
	logic [ADDR_W-1:0] wa_hold;
	logic [DATA_W-1:0] w1_hold;
	logic [LANES-1:0] l1_hold;
	logic got0;
	assign req_ready = phase_true;
	always_ff @(posedge clk) begin
		if (srst) begin
			phase_true <= 1'b1;
			wr_second <= 1'b0;
			wa_hold <= '0;
			w1_hold <= '0;
			l1_hold <= '1;
			got0 <= 1'b0;
			rd_burst <= '0;
			rd_done <= 1'b0;
		end else begin
			phase_true <= ~phase_true;
			wr_second <= phase_true && wr_req;
			if (phase_true && wr_req) begin
				wa_hold <= wr_addr;
				w1_hold <= wr_burst[2*DATA_W-1:DATA_W];
				l1_hold <= wr_lanes_n[2*LANES-1:LANES];
			end
			rd_done <= 1'b0;
			if (link.rd_data_valid) begin
				if (!got0) begin
					rd_burst[DATA_W-1:0] <= link.rd_data;
					got0 <= 1'b1;
				end else begin
					rd_burst[2*DATA_W-1:DATA_W] <= link.rd_data;
					got0 <= 1'b0;
					rd_done <= 1'b1;
				end
			end
		end
	end
	// Port selects only asserted in the true phase, lane selects in both phases
	assign link.in_clk_phase = phase_true; // R9
	assign link.read_port_select_n = !(phase_true && rd_req); // R1 R6
	assign link.write_port_select_n = !(phase_true && wr_req); // R1 R5
	assign link.addr = phase_true ? rd_addr : wa_hold; // R5 R6
	assign link.wr_data = phase_true ? wr_burst[DATA_W-1:0] : w1_hold;
	assign link.byte_lane_write_select_n = phase_true ? wr_lanes_n[LANES-1:0] : (wr_second ? l1_hold : '1); // R13
	assign link.out_clk_hold_high = single_clock;
endmodule

/* File: tb/bsr_link_assertions.sv */
// Protocol checker on the link between the two ends
module bsr_link_assertions (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_clk_phase,
	input wire logic read_port_select_n,
	input wire logic rd_data_oe,
	input wire logic rd_data_valid,
	input wire logic cal_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic [10:0] gap;
	logic seen;
	wire rd_go = in_clk_phase && !read_port_select_n;
	// Cycles since the last calibration pulse
	always_ff @(posedge clk) begin
		gap <= (srst || cal_pulse) ? 11'h000 : gap + 11'h001;
		seen <= !srst && (seen || cal_pulse);
	end
	a_read_burst: assert property (rd_go && !rd_data_oe |-> ##3 rd_data_oe [*2] ##1 !rd_data_oe)
		else $error("bad burst");
	a_oe_cause: assert property ($rose(rd_data_oe) |-> $past(rd_go, 3))
		else $error("stray output");
	a_idle_float: assert property (in_clk_phase && read_port_select_n && !rd_data_oe && !$past(rd_go, 2)
		|-> ##2 !rd_data_oe)
		else $error("idle output");
	a_valid_oe: assert property ($rose(rd_data_valid) |-> rd_data_oe ##1 rd_data_oe ##1 !rd_data_oe)
		else $error("valid mismatch");
	a_cal_period: assert property (cal_pulse && seen |-> gap == 11'h3FF)
		else $error("cal spacing");
	a_cal_single: assert property (cal_pulse |=> !cal_pulse)
		else $error("cal width");
	a_phase_turn: assert property (!$past(srst) |-> in_clk_phase != $past(in_clk_phase))
		else $error("phase stuck");
	a_reset_float: assert property (disable iff (1'b0) srst |=> !rd_data_oe && !cal_pulse)
		else $error("reset output");
	c_read: cover property (rd_go);
	c_burst: cover property (rd_data_oe);
	c_cal: cover property (cal_pulse && seen);
endmodule

/* File: tb/dual_port_ddr_burst_sram_ports_tb.sv */
// Bench joining device and controller ends
module dual_port_ddr_burst_sram_ports_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic srst = 1;
	logic wr_req = 0;
	logic rd_req = 0;
	logic single_clock = 0;
	logic [7:0] wr_addr = 8'h00;
	logic [7:0] rd_addr = 8'h00;
	logic [35:0] wr_burst = 36'h0;
	logic [3:0] wr_lanes_n = 4'hF;
	logic req_ready, rd_done, cal_pulse, single_clock_mode;
	logic [35:0] rd_burst;
	int errors = 0;
	int n_tests = 0;
	bsr_if link ();
	bsr_device bsr_device_i (.clk, .srst, .link, .cal_pulse, .single_clock_mode);
	bsr_controller bsr_controller_i (.clk, .srst, .link, .single_clock, .wr_req, .wr_addr, .wr_burst,
		.wr_lanes_n, .rd_req, .rd_addr, .req_ready, .rd_burst, .rd_done);
	bsr_link_assertions bsr_link_assertions_i (.clk, .srst, .in_clk_phase(link.in_clk_phase),
		.read_port_select_n(link.read_port_select_n), .rd_data_oe(link.rd_data_oe),
		.rd_data_valid(link.rd_data_valid), .cal_pulse);
	always #20 clk = ~clk;
	task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
		n_tests++;
		if (s !== e) begin
			$display("BAD %s expected %h seen %h", n, e, s);
			errors++;
		end
	endtask
	// One request at the next true phase
	task automatic issue(input logic w, input logic r, input logic [7:0] wa, input logic [35:0] wb,
		input logic [3:0] wl, input logic [7:0] ra);
		@(negedge clk);
		while (req_ready !== 1'b1) @(negedge clk);
		wr_req = w;
		rd_req = r;
		wr_addr = wa;
		wr_burst = wb;
		wr_lanes_n = wl;
		rd_addr = ra;
		@(negedge clk);
		wr_req = 0;
		rd_req = 0;
	endtask
	task automatic rd_wait(input logic [35:0] e);
		int i;
		for (i = 0; i < 8 && rd_done !== 1'b1; i++) @(negedge clk);
		chk("rd_done", 36'h1, rd_done);
		chk("rd_burst", e, rd_burst);
	endtask
	task automatic t_lanes;
		issue(1, 0, 8'h05, {18'h12345, 18'h0ABCD}, 4'h0, 8'h00);
		issue(1, 0, 8'h05, {18'h3FFFF, 18'h3FFFF}, 4'h6, 8'h00);
		issue(1, 0, 8'h05, 36'h0, 4'hF, 8'h00);
		issue(0, 1, 8'h00, 36'h0, 4'hF, 8'h05);
		rd_wait({18'h3FF45, 18'h0ABFF});
	endtask
	task automatic t_conc;
		issue(1, 1, 8'h07, {18'h2AAAA, 18'h15555}, 4'h0, 8'h05);
		rd_wait({18'h3FF45, 18'h0ABFF});
		issue(0, 1, 8'h00, 36'h0, 4'hF, 8'h07);
		rd_wait({18'h2AAAA, 18'h15555});
	endtask
	// Read beats seen on the link itself
	task automatic t_wire;
		issue(1, 0, 8'h09, {18'h0F0F0, 18'h30303}, 4'h0, 8'h00);
		issue(0, 1, 8'h00, 36'h0, 4'hF, 8'h09);
		repeat (2) @(negedge clk);
		chk("oe", 36'h1, link.rd_data_oe);
		chk("beat0", 36'h30303, link.rd_data);
		@(negedge clk);
		chk("beat1", 36'h0F0F0, link.rd_data);
		@(negedge clk);
		chk("oe", 36'h0, link.rd_data_oe);
	endtask
	task automatic t_cal;
		int i;
		int c;
		c = 0;
		for (i = 0; i < 2048; i++) begin
			@(negedge clk);
			c += cal_pulse;
		end
		chk("cal_count", 36'h2, c);
		chk("single_clock_mode", 36'h0, single_clock_mode);
	endtask
	// Mid-run reset with the single clock strap raised
	task automatic t_strap;
		@(negedge clk);
		single_clock = 1;
		srst = 1;
		repeat (2) @(negedge clk);
		srst = 0;
		repeat (2) @(negedge clk);
		chk("single_clock_mode", 36'h1, single_clock_mode);
		single_clock = 0;
		repeat (2) @(negedge clk);
		chk("single_clock_mode", 36'h1, single_clock_mode);
		chk("oe", 36'h0, link.rd_data_oe);
	endtask
	task automatic complete_run;
		if (errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		srst = 0;
		t_lanes();
		t_conc();
		t_wire();
		t_cal();
		t_strap();
		complete_run();
	end
	initial begin
		#200000;
		errors++;
		complete_run();
	end
endmodule
